/* File: hw/tmr16_device.sv */
// Timer end: 16-bit counter, compare, capture and byte access logic.
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
// Operation
// RL1: Wide registers move as two byte operations.
// RL2: One shared high byte holding register.
// RL3: Low byte write loads whole register.
// RL4: High byte write touches holding register only.
// RL5: Low byte read copies upper byte into holding.
// RL6: Capture high read returns holding register.
// RL7: Compare reads bypass holding register entirely.
// RL8: CPU writes high byte before low byte.
// RL9: CPU reads low byte before high byte.
// RL10: CPU keeps two-byte accesses uninterrupted.
// RL11: Bottom is count value zero.
// RL12: Maximum is count value all ones.
// RL13: Ceiling fixed, compare A or capture by mode.
// RL14: Compares run continuously, matches set flags.
// RL15: Flags visible together, each individually masked.
// RL16: Clock select picks tick source; none stops.
// RL17: Compare A as ceiling: no output, buffered. In mode 4 output A still toggles on match and compare A loads at once.
// RL18: Control registers plain eight bit access.
// RL19: Filtered edge on pin or comparator captures.
// RL20: Mode bit three in B; forces in A.
module tmr16_device (
   input wire logic MCLK,
   input wire logic RST_N,
   tmr16_bus_if.dev BUS,
   input wire logic EXT_COUNT_PIN,
   input wire logic CAPTURE_INPUT_PIN,
   input wire logic COMPARATOR_IN,
   output logic COMPARE_OUTPUT_PIN_A,
   output logic COMPARE_OUTPUT_PIN_B,
   output logic IRQ_REQ
);
   logic [7:0] hold_q;
   logic [15:0] cnt_q;
   logic [15:0] cmpa_q;
   logic [15:0] cmpb_q;
   logic [15:0] cmpa_buf_q;
   logic [15:0] cmpb_buf_q;
   logic [15:0] cap_q;
   logic [7:0] cta_q;
   logic [7:0] ctb_q;
   logic [3:0] flag_q;
   logic [3:0] mask_q;
   logic [7:0] rdata_q;
   logic [9:0] ps_q;
   logic [2:0] sync1_q;
   logic [2:0] sync2_q;
   logic ext_prev_q;
   logic [1:0] filt_cnt_q;
   logic filt_q;
   logic filt_prev_q;
   logic outa_q;
   logic outb_q;
   logic irq_q;
   logic [3:0] mode;
   logic [15:0] top;
   logic [15:0] wval;
   logic pwm;
   logic top_is_a;
   logic top_is_cap;
   logic tick;
   logic at_top;
   logic match_a;
   logic match_b;
   logic cap_src;
   logic cap_evt;
   logic force_a;
   logic force_b;
   logic [3:0] flag_set;
   logic [3:0] flag_clr;

   // Mode bits come from both control registers; bit three lives in B.
   assign mode = {ctb_q[tmr16_pkg::CTB_WGM3], cta_q[tmr16_pkg::CTA_WGM_LO +: 3]}; // RL20
   assign wval = {hold_q, BUS.wdata}; // RL3

   // Ceiling selection and mode classes.
   always_comb begin
      top_is_a = 1'b0;
      top_is_cap = 1'b0;
      case (mode)
         4'h1, 4'h5: top = tmr16_pkg::TOP_8; // RL13
         4'h2, 4'h6: top = tmr16_pkg::TOP_9; // RL13
         4'h3, 4'h7: top = tmr16_pkg::TOP_10; // RL13
         4'h4, 4'h9, 4'hb, 4'hf: begin
            top = cmpa_q; // RL13
            top_is_a = 1'b1;
         end
         4'h8, 4'ha, 4'hc, 4'he: begin
            top = cap_q; // RL13
            top_is_cap = 1'b1;
         end
         default: top = tmr16_pkg::CNT_MAX; // RL12
      endcase
   end
   assign pwm = (mode != 4'h0) && (mode != 4'h4) && (mode != 4'hc) && (mode != 4'hd);

   // Two-stage synchronisers for the three asynchronous inputs.
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
         ext_prev_q <= 1'b0;
      end else begin
         sync1_q <= {COMPARATOR_IN, CAPTURE_INPUT_PIN, EXT_COUNT_PIN};
         sync2_q <= sync1_q;
         ext_prev_q <= sync2_q[0];
      end
   end

   // The prescaler runs free, so the first prescaled tick may come early.
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         ps_q <= 10'h000;
      end else begin
         ps_q <= ps_q + 10'h001;
      end
   end

   // Tick source selection.
   always_comb begin
      case (ctb_q[tmr16_pkg::CTB_CS_LO +: 3])
         3'h1: tick = 1'b1; // RL16
         3'h2: tick = (ps_q & tmr16_pkg::PS_8) == tmr16_pkg::PS_8; // RL16
         3'h3: tick = (ps_q & tmr16_pkg::PS_64) == tmr16_pkg::PS_64; // RL16
         3'h4: tick = (ps_q & tmr16_pkg::PS_256) == tmr16_pkg::PS_256; // RL16
         3'h5: tick = ps_q == tmr16_pkg::PS_1024; // RL16
         3'h6: tick = ext_prev_q && !sync2_q[0]; // RL16
         3'h7: tick = !ext_prev_q && sync2_q[0]; // RL16
         default: tick = 1'b0; // RL16
      endcase
   end

   assign at_top = cnt_q == top;
   assign match_a = tick && (cnt_q == cmpa_q); // RL14
   assign match_b = tick && (cnt_q == cmpb_q); // RL14
   assign force_a = BUS.wr && BUS.addr == tmr16_pkg::A_CTRL_A && BUS.wdata[tmr16_pkg::CTA_FORCE_A]
      && !pwm; // RL20
   assign force_b = BUS.wr && BUS.addr == tmr16_pkg::A_CTRL_A && BUS.wdata[tmr16_pkg::CTA_FORCE_B]
      && !pwm; // RL20

   // Holding register: high byte writes and low byte reads of count or capture.
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         hold_q <= 8'h00;
      end else if (BUS.wr && (BUS.addr == tmr16_pkg::A_CNT_H || BUS.addr == tmr16_pkg::A_CMPA_H
                   || BUS.addr == tmr16_pkg::A_CMPB_H || BUS.addr == tmr16_pkg::A_CAP_H)) begin
         hold_q <= BUS.wdata; // RL2 RL4
      end else if (BUS.rd && BUS.addr == tmr16_pkg::A_CNT_L) begin
         hold_q <= cnt_q[15:8]; // RL5
      end else if (BUS.rd && BUS.addr == tmr16_pkg::A_CAP_L) begin
         hold_q <= cap_q[15:8]; // RL5
      end
   end

   // Counter; a CPU write beats any count or wrap in the same cycle.
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         cnt_q <= tmr16_pkg::CNT_BOTTOM;
      end else if (BUS.wr && BUS.addr == tmr16_pkg::A_CNT_L) begin
         cnt_q <= wval; // RL3
      end else if (tick) begin
         cnt_q <= at_top ? tmr16_pkg::CNT_BOTTOM : cnt_q + 16'h0001; // RL11
      end
   end

   // Compare registers; in pulse-width modes the active copy updates at the ceiling.
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         cmpa_q <= tmr16_pkg::CNT_BOTTOM;
         cmpb_q <= tmr16_pkg::CNT_BOTTOM;
         cmpa_buf_q <= tmr16_pkg::CNT_BOTTOM;
         cmpb_buf_q <= tmr16_pkg::CNT_BOTTOM;
      end else begin
         if (BUS.wr && BUS.addr == tmr16_pkg::A_CMPA_L) begin
            cmpa_buf_q <= wval; // RL3
         end
         if (BUS.wr && BUS.addr == tmr16_pkg::A_CMPB_L) begin
            cmpb_buf_q <= wval; // RL3
         end
         if (!pwm) begin
            cmpa_q <= (BUS.wr && BUS.addr == tmr16_pkg::A_CMPA_L) ? wval : cmpa_buf_q;
            cmpb_q <= (BUS.wr && BUS.addr == tmr16_pkg::A_CMPB_L) ? wval : cmpb_buf_q;
         end else if (tick && at_top) begin
            cmpa_q <= cmpa_buf_q; // RL17
            cmpb_q <= cmpb_buf_q;
         end
      end
   end

   // Input capture filter: the level must hold for four samples when enabled.
   assign cap_src = ctb_q[tmr16_pkg::CTB_CAP_SRC] ? sync2_q[2] : sync2_q[1];
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         filt_cnt_q <= 2'h0;
         filt_q <= 1'b0;
         filt_prev_q <= 1'b0;
      end else begin
         filt_prev_q <= filt_q;
         if (!ctb_q[tmr16_pkg::CTB_FILT_EN] || cap_src == filt_q) begin
            filt_cnt_q <= 2'h0;
            filt_q <= cap_src;
         end else if (filt_cnt_q == tmr16_pkg::FILT_LAST) begin
            filt_cnt_q <= 2'h0;
            filt_q <= cap_src; // RL19
         end else begin
            filt_cnt_q <= filt_cnt_q + 2'h1;
         end
      end
   end
   assign cap_evt = !top_is_cap && (ctb_q[tmr16_pkg::CTB_CAP_RISE] ?
      (filt_q && !filt_prev_q) : (!filt_q && filt_prev_q)); // RL19

   // Capture register is writable only while it serves as the ceiling.
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         cap_q <= tmr16_pkg::CNT_BOTTOM;
      end else if (BUS.wr && BUS.addr == tmr16_pkg::A_CAP_L && top_is_cap) begin
         cap_q <= wval; // RL3
      end else if (cap_evt) begin
         cap_q <= cnt_q; // RL19
      end
   end

   // Control and mask registers; force bits are strobes and are not stored.
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         cta_q <= 8'h00;
         ctb_q <= 8'h00;
         mask_q <= 4'h0;
      end else if (BUS.wr) begin
         if (BUS.addr == tmr16_pkg::A_CTRL_A) begin
            cta_q <= BUS.wdata & tmr16_pkg::CTA_RD_MASK; // RL18
         end
         if (BUS.addr == tmr16_pkg::A_CTRL_B) begin
            ctb_q <= BUS.wdata; // RL18
         end
         if (BUS.addr == tmr16_pkg::A_MASK) begin
            mask_q <= BUS.wdata[3:0]; // RL15
         end
      end
   end

   // Sticky flags, cleared by writing one; a new event wins over its clear.
   always_comb begin
      flag_set = 4'h0;
      flag_set[tmr16_pkg::FLG_OVF] = tick && at_top;
      flag_set[tmr16_pkg::FLG_MA] = match_a; // RL14
      flag_set[tmr16_pkg::FLG_MB] = match_b; // RL14
      flag_set[tmr16_pkg::FLG_CAP] = cap_evt;
      flag_clr = (BUS.wr && BUS.addr == tmr16_pkg::A_FLAG) ? BUS.wdata[3:0] : 4'h0;
   end
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         flag_q <= 4'h0;
         irq_q <= 1'b0;
      end else begin
         flag_q <= (flag_q & ~flag_clr) | flag_set; // RL15
         irq_q <= |(flag_q & mask_q); // RL15
      end
   end

   // Compare outputs: toggle on match outside pulse-width modes, else a level.
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         outa_q <= 1'b0;
         outb_q <= 1'b0;
      end else if (pwm) begin
         outa_q <= !top_is_a && (cnt_q < cmpa_q); // RL17
         outb_q <= cnt_q < cmpb_q;
      end else begin
         outa_q <= outa_q ^ (match_a || force_a);
         outb_q <= outb_q ^ (match_b || force_b);
      end
   end

   // Read data is registered and valid the cycle after the read strobe.
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         rdata_q <= 8'h00;
      end else if (BUS.rd) begin
         case (BUS.addr)
            tmr16_pkg::A_CNT_L: rdata_q <= cnt_q[7:0]; // RL5
            tmr16_pkg::A_CNT_H: rdata_q <= hold_q; // RL1
            tmr16_pkg::A_CMPA_L: rdata_q <= cmpa_buf_q[7:0]; // RL7
            tmr16_pkg::A_CMPA_H: rdata_q <= cmpa_buf_q[15:8]; // RL7
            tmr16_pkg::A_CMPB_L: rdata_q <= cmpb_buf_q[7:0]; // RL7
            tmr16_pkg::A_CMPB_H: rdata_q <= cmpb_buf_q[15:8]; // RL7
            tmr16_pkg::A_CAP_L: rdata_q <= cap_q[7:0]; // RL5
            tmr16_pkg::A_CAP_H: rdata_q <= hold_q; // RL6
            tmr16_pkg::A_CTRL_A: rdata_q <= cta_q; // RL18
            tmr16_pkg::A_CTRL_B: rdata_q <= ctb_q; // RL18
            tmr16_pkg::A_FLAG: rdata_q <= {4'h0, flag_q}; // RL15
            tmr16_pkg::A_MASK: rdata_q <= {4'h0, mask_q};
            default: rdata_q <= 8'h00;
         endcase
      end
   end

   assign BUS.rdata = rdata_q;
   assign COMPARE_OUTPUT_PIN_A = outa_q;
   assign COMPARE_OUTPUT_PIN_B = outb_q;
   assign IRQ_REQ = irq_q;
endmodule

/* File: common/tmr16_pkg.sv */
// Shared constants for the 16-bit timer byte access block and its CPU-side controller.
package tmr16_pkg;
   // Byte locations on the 8-bit timer bus.
   localparam logic [3:0] A_CNT_L = 4'h0;
   localparam logic [3:0] A_CNT_H = 4'h1;
   localparam logic [3:0] A_CMPA_L = 4'h2;
   localparam logic [3:0] A_CMPA_H = 4'h3;
   localparam logic [3:0] A_CMPB_L = 4'h4;
   localparam logic [3:0] A_CMPB_H = 4'h5;
   localparam logic [3:0] A_CAP_L = 4'h6;
   localparam logic [3:0] A_CAP_H = 4'h7;
   localparam logic [3:0] A_CTRL_A = 4'h8;
   localparam logic [3:0] A_CTRL_B = 4'h9;
   localparam logic [3:0] A_FLAG = 4'ha;
   localparam logic [3:0] A_MASK = 4'hb;
   localparam logic [3:0] A_HI_OFS = 4'h1;
   // Control register A fields.
   localparam int CTA_WGM_LO = 0;
   localparam int CTA_FORCE_B = 6;
   localparam int CTA_FORCE_A = 7;
   localparam logic [7:0] CTA_RD_MASK = 8'h07;
   // Control register B fields.
   localparam int CTB_CS_LO = 0;
   localparam int CTB_WGM3 = 3;
   localparam int CTB_CAP_SRC = 5;
   localparam int CTB_CAP_RISE = 6;
   localparam int CTB_FILT_EN = 7;
   // Flag and mask bit positions.
   localparam int FLG_OVF = 0;
   localparam int FLG_MA = 1;
   localparam int FLG_MB = 2;
   localparam int FLG_CAP = 3;
   // Count limits.
   localparam logic [15:0] CNT_BOTTOM = 16'h0000;
   localparam logic [15:0] CNT_MAX = 16'hffff;
   localparam logic [15:0] TOP_8 = 16'h00ff;
   localparam logic [15:0] TOP_9 = 16'h01ff;
   localparam logic [15:0] TOP_10 = 16'h03ff;
   // Prescaler tap masks for divide by 8, 64, 256 and 1024.
   localparam logic [9:0] PS_8 = 10'h007;
   localparam logic [9:0] PS_64 = 10'h03f;
   localparam logic [9:0] PS_256 = 10'h0ff;
   localparam logic [9:0] PS_1024 = 10'h3ff;
   // Noise filter: last count value; four samples must agree before the level is accepted.
   localparam logic [1:0] FILT_LAST = 2'h3;
   // Controller registers on APB.
   localparam logic [7:0] R_CMD = 8'h00;
   localparam logic [7:0] R_STATUS = 8'h04;
   localparam int CMD_ADDR_LO = 0;
   localparam int CMD_WIDE = 4;
   localparam int CMD_READ = 5;
   localparam int CMD_DATA_LO = 16;
   localparam int STS_BUSY = 0;
   localparam int STS_DATA_LO = 16;
endpackage

/* File: common/tmr16_bus_if.sv */
// Byte-wide bus between the CPU-side controller and the timer.
`timescale 1ns/1ps
interface tmr16_bus_if;
   logic [3:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic wr;
   logic rd;
   modport dev (input addr, input wdata, input wr, input rd, output rdata);
   modport cpu (output addr, output wdata, output wr, output rd, input rdata);
endinterface

/* File: hw/tmr16_host.sv */
// CPU end: APB command port that runs byte sequences on the timer bus.
`timescale 1ns/1ps
module tmr16_host (
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   tmr16_bus_if.cpu BUS
);
   typedef enum logic [5:0] {
      S_IDLE = 6'h01,
      S_WR_HI = 6'h02,
      S_WR_LO = 6'h04,
      S_RD_LO = 6'h08,
      S_RD_HI = 6'h10,
      S_RD_LAST = 6'h20
   } tmr16_state_type;

   tmr16_state_type state_q;
   logic [3:0] addr_q;
   logic [7:0] wdata_q;
   logic wr_q;
   logic rd_q;
   logic wide_q;
   logic [7:0] lo_byte_q;
   logic [15:0] res_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic start;
   logic busy;

   assign busy = state_q != S_IDLE;
   // Commands that arrive while busy are dropped; software polls the busy bit.
   assign start = PSEL && PENABLE && PWRITE && PADDR == tmr16_pkg::R_CMD && !busy;

   // Sequencer: a wide access runs its two bytes back to back so nothing intervenes.
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         state_q <= S_IDLE;
         addr_q <= 4'h0;
         wdata_q <= 8'h00;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         wide_q <= 1'b0;
         lo_byte_q <= 8'h00;
         res_q <= 16'h0000;
      end else begin
         case (state_q)
            S_IDLE: begin
               if (start) begin
                  wide_q <= PWDATA[tmr16_pkg::CMD_WIDE];
                  lo_byte_q <= PWDATA[tmr16_pkg::CMD_DATA_LO +: 8];
                  if (PWDATA[tmr16_pkg::CMD_READ]) begin
                     addr_q <= PWDATA[tmr16_pkg::CMD_ADDR_LO +: 4]; // RL9
                     rd_q <= 1'b1;
                     state_q <= S_RD_LO;
                  end else if (PWDATA[tmr16_pkg::CMD_WIDE]) begin
                     addr_q <= PWDATA[tmr16_pkg::CMD_ADDR_LO +: 4] + tmr16_pkg::A_HI_OFS; // RL8
                     wdata_q <= PWDATA[tmr16_pkg::CMD_DATA_LO + 8 +: 8]; // RL8
                     wr_q <= 1'b1;
                     state_q <= S_WR_HI;
                  end else begin
                     addr_q <= PWDATA[tmr16_pkg::CMD_ADDR_LO +: 4];
                     wdata_q <= PWDATA[tmr16_pkg::CMD_DATA_LO +: 8];
                     wr_q <= 1'b1;
                     state_q <= S_WR_LO;
                  end
               end
            end
            S_WR_HI: begin
               addr_q <= addr_q - tmr16_pkg::A_HI_OFS; // RL1 RL10
               wdata_q <= lo_byte_q;
               state_q <= S_WR_LO;
            end
            S_WR_LO: begin
               wr_q <= 1'b0;
               state_q <= S_IDLE;
            end
            S_RD_LO: begin
               if (wide_q) begin
                  addr_q <= addr_q + tmr16_pkg::A_HI_OFS; // RL1 RL9 RL10
                  state_q <= S_RD_HI;
               end else begin
                  rd_q <= 1'b0;
                  state_q <= S_RD_LAST;
               end
            end
            S_RD_HI: begin
               res_q[7:0] <= BUS.rdata;
               rd_q <= 1'b0;
               state_q <= S_RD_LAST;
            end
            S_RD_LAST: begin
               if (wide_q) begin
                  res_q[15:8] <= BUS.rdata;
               end else begin
                  res_q <= {8'h00, BUS.rdata};
               end
               state_q <= S_IDLE;
            end
            default: begin
               wr_q <= 1'b0;
               rd_q <= 1'b0;
               state_q <= S_IDLE;
            end
         endcase
      end
   end

   // APB read data is captured in the setup cycle; the slave never waits.
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         prdata_q <= 32'h00000000;
         pready_q <= 1'b0;
      end else begin
         pready_q <= 1'b1;
         if (PSEL && !PENABLE) begin
            case (PADDR)
               tmr16_pkg::R_STATUS: prdata_q <= {res_q, 15'h0000, busy};
               default: prdata_q <= 32'h00000000;
            endcase
         end
      end
   end

   assign PRDATA = prdata_q;
   assign PREADY = pready_q;
   assign PSLVERR = 1'b0;
   assign BUS.addr = addr_q;
   assign BUS.wdata = wdata_q;
   assign BUS.wr = wr_q;
   assign BUS.rd = rd_q;
endmodule

/* File: tb/tmr16_props.sv */
// Checker on the byte bus between the host and the timer.
`timescale 1ns/1ps
module tmr16_props (
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic wr,
   input wire logic rd
);
   logic [7:0] hold_q;
   logic [15:0] cmp_q [2];
   logic [7:0] ctla_q;
   logic [7:0] ctlb_q;

   // Shadow of what was written; compare and control B reads must return it untouched, control A reads only its masked fields.
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         hold_q <= 8'h00;
         cmp_q <= '{16'h0000, 16'h0000};
         ctla_q <= 8'h00;
         ctlb_q <= 8'h00;
      end else if (wr) begin
         if (addr < 4'h8 && addr[0]) hold_q <= wdata;
         if (addr == tmr16_pkg::A_CMPA_L || addr == tmr16_pkg::A_CMPB_L)
            cmp_q[addr[2]] <= {hold_q, wdata};
         if (addr == tmr16_pkg::A_CTRL_A) ctla_q <= wdata;
         if (addr == tmr16_pkg::A_CTRL_B) ctlb_q <= wdata;
      end
   end

   default clocking @(posedge MCLK); endclocking
   default disable iff (!RST_N);

   a_no_dual_strobe: assert property (!(wr && rd))
      else $error("read and write strobes together");
   a_low_after_high: assert property (wr && addr < 4'h8 && !addr[0] && $past(wr) |->
      $past(addr) == addr + 4'h1) else $error("low byte write not after its high byte");
   a_read_pair_order: assert property (rd && $past(rd) |->
      $past(addr) + 4'h1 == addr && !$past(addr[0])) else $error("wide read out of order");
   a_wr_burst_short: assert property (wr ##1 wr |=> !wr)
      else $error("write strobe longer than two bytes");
   a_cmp_low_direct: assert property (rd && (addr == 4'h2 || addr == 4'h4) |=>
      rdata == cmp_q[$past(addr[2])][7:0]) else $error("compare low byte wrong");
   a_cmp_high_direct: assert property (rd && (addr == 4'h3 || addr == 4'h5) |=>
      rdata == cmp_q[$past(addr[2])][15:8]) else $error("compare high byte wrong");
   a_ctrlb_plain: assert property (rd && addr == tmr16_pkg::A_CTRL_B |=>
      rdata == ctlb_q) else $error("control B readback wrong");
   a_ctrla_fields: assert property (rd && addr == tmr16_pkg::A_CTRL_A |=>
      rdata == (ctla_q & tmr16_pkg::CTA_RD_MASK)) else $error("control A readback wrong");
endmodule

/* File: tb/testbench.sv */
// Self-checking bench: APB host driving the timer over the byte bus.
`timescale 1ns/1ps
module testbench;
   logic MCLK, RST_N, psel, penable, pwrite, ext_pin, cap_pin, pready, pslverr, cmp_a, cmp_b, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, seed, s;
   logic [15:0] res;
   int err_total, tests_run, cyc;
   int mdl_reg [3];

   tmr16_bus_if bus_if ();
   tmr16_host tmr16_host_inst (.MCLK(MCLK), .RST_N(RST_N), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .BUS(bus_if));
   tmr16_device tmr16_device_inst (.MCLK(MCLK), .RST_N(RST_N), .BUS(bus_if),
      .EXT_COUNT_PIN(ext_pin), .CAPTURE_INPUT_PIN(cap_pin), .COMPARATOR_IN(1'b0),
      .COMPARE_OUTPUT_PIN_A(cmp_a), .COMPARE_OUTPUT_PIN_B(cmp_b), .IRQ_REQ(irq));
   tmr16_props tmr16_props_inst (.MCLK(MCLK), .RST_N(RST_N), .addr(bus_if.addr),
      .wdata(bus_if.wdata), .rdata(bus_if.rdata), .wr(bus_if.wr), .rd(bus_if.rd));

   // Free-running system clock.
   initial begin
      MCLK = 1'b0;
      forever #5 MCLK = ~MCLK;
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // One APB transfer; an idle cycle follows so psel is never assigned twice in one step.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge MCLK);
      penable <= 1'b1;
      // No wait-state count is assumed; only the hang guard ends a stuck transfer.
      do begin
         @(posedge MCLK);
      end while (pready !== 1'b1);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge MCLK);
   endtask

   // Issue one command and poll status until the byte sequence is over.
   task automatic cmd(input logic [3:0] a, input logic wide, input logic rd, input logic [15:0] d);
      apb(1'b1, tmr16_pkg::R_CMD, {d, 10'h000, rd, wide, a}, s);
      s = 32'h0000_0001;
      while (s[tmr16_pkg::STS_BUSY] !== 1'b0) begin
         apb(1'b0, tmr16_pkg::R_STATUS, 32'h0000_0000, s);
      end
      res = s[31:16];
   endtask

   // Hang guard: twenty thousand cycles cover the whole sequence many times over.
   always @(posedge MCLK) begin
      cyc <= cyc + 1;
      ext_pin <= seed[3];
      if (cyc == 20000) begin
         err_total++;
         tally_and_finish();
      end
   end

   initial begin
      seed = 32'hf649fb75;
      {psel, penable, pwrite, ext_pin, cap_pin, RST_N} = 6'h00;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      err_total = 0;
      tests_run = 0;
      cyc = 0;
      mdl_reg = '{0, 0, 0};
      repeat (8) @(posedge MCLK);
      RST_N <= 1'b1;
      @(posedge MCLK);
      // Random wide traffic on count and compares; the clock is stopped so values stay put.
      for (int i = 0; i < 24; i++) begin
         seed = lfsr_next(seed);
         mdl_reg[i % 3] = int'(seed[15:0]);
         cmd(4'(2 * (i % 3)), 1'b1, 1'b0, seed[15:0]);
         repeat (i % 4) @(posedge MCLK);
         cmd(4'(2 * (i % 3)), 1'b1, 1'b1, 16'h0000);
         chk_data(res, 16'(mdl_reg[i % 3]));
      end
      // A lone high byte write must not reach the count.
      cmd(tmr16_pkg::A_CNT_H, 1'b0, 1'b0, 16'h00ab);
      cmd(tmr16_pkg::A_CNT_L, 1'b1, 1'b1, 16'h0000);
      chk_data(res, 16'(mdl_reg[0]));
      // Compare reads in between must leave the holding byte as written.
      cmd(tmr16_pkg::A_CNT_H, 1'b0, 1'b0, 16'h00ab);
      cmd(tmr16_pkg::A_CMPA_L, 1'b1, 1'b1, 16'h0000);
      chk_data(res, 16'(mdl_reg[1]));
      cmd(tmr16_pkg::A_CNT_L, 1'b0, 1'b0, 16'h0034);
      cmd(tmr16_pkg::A_CNT_L, 1'b1, 1'b1, 16'h0000);
      chk_data(res, 16'hab34);
      // Capture high returns the holding byte just filled by the count low read.
      cmd(tmr16_pkg::A_CAP_H, 1'b0, 1'b1, 16'h0000);
      chk_data(res, 16'h00ab);
      // Control registers: plain byte access, force strobes read as zero.
      cmd(tmr16_pkg::A_CTRL_A, 1'b0, 1'b0, 16'h00ff);
      cmd(tmr16_pkg::A_CTRL_A, 1'b0, 1'b1, 16'h0000);
      chk_data(res, 16'h0007);
      // Mode 7 is pulse-width: each output is the level count below compare.
      chk_bit(cmp_a, 16'hab34 < mdl_reg[1]);
      chk_bit(cmp_b, 16'hab34 < mdl_reg[2]);
      cmd(tmr16_pkg::A_CTRL_B, 1'b0, 1'b0, {8'h00, seed[7:4], 4'h0});
      cmd(tmr16_pkg::A_CTRL_B, 1'b0, 1'b1, 16'h0000);
      chk_data(res, {8'h00, seed[7:4], 4'h0});
      cmd(4'hc, 1'b0, 1'b1, 16'h0000);
      chk_data(res, 16'h0000);
      apb(1'b0, 8'h08, 32'h0000_0000, s);
      chk_data(s[15:0], 16'h0000);
      chk_bit(pslverr, 1'b0);
      // Run from zero past compare A in the full-range mode; the match must raise the request.
      cmd(tmr16_pkg::A_CTRL_A, 1'b0, 1'b0, 16'h0000);
      cmd(tmr16_pkg::A_CMPA_L, 1'b1, 1'b0, 16'h0040);
      cmd(tmr16_pkg::A_CNT_L, 1'b1, 1'b0, 16'h0000);
      cmd(tmr16_pkg::A_MASK, 1'b0, 1'b0, 16'h0002);
      cmd(tmr16_pkg::A_CTRL_B, 1'b0, 1'b0, 16'h0001);
      repeat (100) @(posedge MCLK);
      cmd(tmr16_pkg::A_CTRL_B, 1'b0, 1'b0, 16'h0000);
      chk_bit(irq, 1'b1);
      cmd(tmr16_pkg::A_FLAG, 1'b0, 1'b1, 16'h0000);
      chk_data(res & 16'h0002, 16'h0002);
      cmd(tmr16_pkg::A_MASK, 1'b0, 1'b0, 16'h0000);
      repeat (2) @(posedge MCLK);
      chk_bit(irq, 1'b0);
      cmd(tmr16_pkg::A_FLAG, 1'b0, 1'b0, 16'h0002);
      cmd(tmr16_pkg::A_FLAG, 1'b0, 1'b1, 16'h0000);
      chk_data(res & 16'h0002, 16'h0000);
      // Eight-bit fixed ceiling: the count must wrap at 0x00ff and flag it.
      cmd(tmr16_pkg::A_CTRL_A, 1'b0, 1'b0, 16'h0001);
      cmd(tmr16_pkg::A_CNT_L, 1'b1, 1'b0, 16'h00f0);
      cmd(tmr16_pkg::A_CTRL_B, 1'b0, 1'b0, 16'h0001);
      repeat (40) @(posedge MCLK);
      cmd(tmr16_pkg::A_CTRL_B, 1'b0, 1'b0, 16'h0000);
      cmd(tmr16_pkg::A_CNT_L, 1'b1, 1'b1, 16'h0000);
      chk_bit(res < 16'h0040, 1'b1);
      cmd(tmr16_pkg::A_FLAG, 1'b0, 1'b1, 16'h0000);
      chk_data(res & 16'h0001, 16'h0001);
      // Rising pin edge with the clock stopped: the capture must hold the known count.
      cmd(tmr16_pkg::A_CNT_L, 1'b1, 1'b0, 16'h1234);
      cmd(tmr16_pkg::A_CTRL_B, 1'b0, 1'b0, 16'h0040);
      cap_pin <= 1'b1;
      repeat (8) @(posedge MCLK);
      cmd(tmr16_pkg::A_CAP_L, 1'b1, 1'b1, 16'h0000);
      chk_data(res, 16'h1234);
      cmd(tmr16_pkg::A_FLAG, 1'b0, 1'b1, 16'h0000);
      chk_data(res & 16'h0008, 16'h0008);
      tally_and_finish();
   end
endmodule
